// >>> hw/cpuoad_decoder.sv
/*
 * Instruction fetch and operand addressing decoder. Fetches prebyte, opcode,
 * address bytes and memory pointers, then presents one decoded instruction.
 * Assumes a same-clock memory port answering each request with a one-cycle
 * ack, and a consumer that reloads the program counter on jumps.
 */
`timescale 1ns/1ps

module cpuoad_decoder
    import cpuoad_pkg::*;
(
    input  wire logic         core_clk_i,
    input  wire logic         reset_i,
    input  wire logic         pc_load_i,
    input  wire logic [15:0]  pc_value_i,
    input  wire logic [7:0]   x_index_i,
    input  wire logic [7:0]   y_index_i,
    output logic              mem_req_o,
    output logic [15:0]       mem_addr_o,
    input  wire logic         mem_ack_i,
    input  wire logic [7:0]   mem_rdata_i,
    output logic              dec_valid_o,
    input  wire logic         dec_ready_i,
    output cpuoad_dec_t       dec_o,
    output logic              illegal_reset_o
);

    // ------------------------------------------------------------------
    // opcode map
    // ------------------------------------------------------------------
    function automatic logic is_prebyte(input logic [7:0] code);
        return (code == Y_REGISTER_PREBYTE) || (code == Y_INDIRECT_PREBYTE)
            || (code == INDIRECT_PREBYTE);
    endfunction : is_prebyte

    function automatic logic op_legal(input logic [7:0] code);
        case (code[7:4])
            4'h4:    return INH_LEGAL_GRP4[code[3:0]];
            4'h5:    return INH_LEGAL_GRP5[code[3:0]];
            4'h8:    return INH_LEGAL_GRP8[code[3:0]];
            4'h9:    return INH_LEGAL_GRP9[code[3:0]];
            default: return 1'b1;
        endcase
    endfunction : op_legal

    function automatic cpuoad_mode_t base_mode(input logic [7:0] code);
        if (code == RELATIVE_SUBROUTINE_CALL) begin
            return MODE_REL_D;
        end
        case (code[7:4])
            4'h0:    return MODE_BTR_D;
            4'h1:    return MODE_BIT_D;
            4'h2:    return MODE_REL_D;
            4'h3:    return MODE_DIR_S;
            4'h6:    return MODE_IDX_S;
            4'h7:    return MODE_IDX_0;
            4'hA:    return MODE_IMM;
            4'hB:    return MODE_DIR_S;
            4'hC:    return MODE_DIR_L;
            4'hD:    return MODE_IDX_L;
            4'hE:    return MODE_IDX_S;
            4'hF:    return MODE_IDX_0;
            default: return MODE_INH;
        endcase
    endfunction : base_mode

    function automatic cpuoad_sel_t apply_prebyte(input logic [7:0]  code,
                                                  input cpuoad_pre_t pre);
        cpuoad_sel_t  sel;
        cpuoad_mode_t m;
        m             = base_mode(code);
        sel.mode      = m;
        sel.use_y     = 1'b0;
        sel.combo_bad = 1'b0;
        case (pre)
            PRE_Y: begin
                if (m inside {MODE_IMM, MODE_DIR_S, MODE_DIR_L, MODE_IDX_0,
                              MODE_IDX_S, MODE_IDX_L, MODE_INH}) begin
                    sel.use_y = 1'b1;
                end else begin
                    sel.combo_bad = 1'b1;
                end
            end
            PRE_IND: begin
                case (m)
                    MODE_DIR_S: sel.mode = MODE_IND_S;
                    MODE_DIR_L: sel.mode = MODE_IND_L;
                    MODE_IDX_S: sel.mode = MODE_IIX_S;
                    MODE_IDX_L: sel.mode = MODE_IIX_L;
                    MODE_REL_D: sel.mode = MODE_REL_I;
                    MODE_BIT_D: sel.mode = MODE_BIT_I;
                    MODE_BTR_D: sel.mode = MODE_BTR_I;
                    default:    sel.combo_bad = 1'b1;
                endcase
            end
            PRE_YIND: begin
                case (m)
                    MODE_IDX_S: sel.mode = MODE_IIX_S;
                    MODE_IDX_L: sel.mode = MODE_IIX_L;
                    default:    sel.combo_bad = 1'b1;
                endcase
                sel.use_y = !sel.combo_bad;
            end
            default: sel.use_y = 1'b0;
        endcase
        return sel;
    endfunction : apply_prebyte

    function automatic logic [1:0] arg_bytes(input cpuoad_mode_t m);
        case (m)
            MODE_INH, MODE_IDX_0:                    return 2'd0;
            MODE_DIR_L, MODE_IDX_L, MODE_BTR_D,
            MODE_BTR_I:                              return 2'd2;
            default:                                 return 2'd1;
        endcase
    endfunction : arg_bytes

    function automatic logic [1:0] ptr_bytes(input cpuoad_mode_t m);
        case (m)
            MODE_IND_L, MODE_IIX_L:                  return 2'd2;
            MODE_IND_S, MODE_IIX_S, MODE_REL_I,
            MODE_BIT_I, MODE_BTR_I:                  return 2'd1;
            default:                                 return 2'd0;
        endcase
    endfunction : ptr_bytes

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    cpuoad_state_t state;
    cpuoad_state_t next_state;
    cpuoad_pre_t   pre;
    cpuoad_sel_t   sel;
    cpuoad_sel_t   op_sel;
    logic [15:0]   pc;
    logic [15:0]   ptr_addr;
    logic [7:0]    opcode;
    logic [7:0]    arg_lo;
    logic [7:0]    arg_hi;
    logic [7:0]    ptr_hi;
    logic [7:0]    ptr_lo;
    logic [1:0]    arg_cnt;
    logic [1:0]    ptr_cnt;
    logic          take;
    logic          bad_code;
    logic          arg_last;
    logic          ptr_last;

    assign take     = mem_req_o && mem_ack_i && !pc_load_i;
    assign op_sel   = apply_prebyte(mem_rdata_i, pre);
    assign bad_code = !op_legal(mem_rdata_i) && !is_prebyte(mem_rdata_i);
    assign arg_last = (arg_cnt + 2'd1) == arg_bytes(sel.mode);
    assign ptr_last = (ptr_cnt + 2'd1) == ptr_bytes(sel.mode);

    assign mem_req_o       = (state == ST_OP) || (state == ST_ARG) || (state == ST_PTR);
    assign mem_addr_o      = (state == ST_PTR) ? ptr_addr : pc;
    assign dec_valid_o     = (state == ST_DONE);
    assign illegal_reset_o = (state == ST_TRAP);

    always_comb begin
        next_state = state;
        case (state)
            ST_OP: begin
                if (take) begin
                    if (bad_code) begin
                        next_state = ST_TRAP;
                    end else if (is_prebyte(mem_rdata_i) && pre == PRE_NONE) begin
                        next_state = ST_OP;
                    end else if (arg_bytes(op_sel.mode) != 2'd0) begin
                        next_state = ST_ARG;
                    end else begin
                        next_state = ST_CALC;
                    end
                end
            end
            ST_ARG: begin
                if (take && arg_last) begin
                    next_state = (ptr_bytes(sel.mode) != 2'd0) ? ST_PTR : ST_CALC;
                end
            end
            ST_PTR: begin
                if (take && ptr_last) begin
                    next_state = ST_CALC;
                end
            end
            ST_CALC: next_state = ST_DONE;
            ST_DONE: begin
                if (dec_ready_i) begin
                    next_state = ST_OP;
                end
            end
            ST_TRAP: next_state = ST_TRAP;
            default: next_state = ST_OP;
        endcase
        if (pc_load_i && state != ST_TRAP) begin
            next_state = ST_OP;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            state <= ST_OP;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------
    // fetch
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            pc <= RESET_PC;
        end else if (pc_load_i && state != ST_TRAP) begin
            pc <= pc_value_i;
        end else if (take && state != ST_PTR) begin
            pc <= pc + 16'h0001;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            pre    <= PRE_NONE;
            opcode <= 8'h00;
            sel    <= '{mode: MODE_INH, use_y: 1'b0, combo_bad: 1'b0};
        end else if (pc_load_i || (state == ST_DONE && dec_ready_i)) begin
            pre <= PRE_NONE;
        end else if (state == ST_OP && take && !bad_code) begin
            if (is_prebyte(mem_rdata_i) && pre == PRE_NONE) begin
                case (mem_rdata_i)
                    Y_REGISTER_PREBYTE: pre <= PRE_Y;
                    INDIRECT_PREBYTE:   pre <= PRE_IND;
                    default:            pre <= PRE_YIND;
                endcase
            end else if (is_prebyte(mem_rdata_i)) begin
                opcode <= mem_rdata_i;
                sel    <= '{mode: MODE_INH, use_y: 1'b0, combo_bad: 1'b1};
            end else begin
                opcode <= mem_rdata_i;
                sel    <= op_sel;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            arg_cnt <= 2'd0;
            arg_lo  <= 8'h00;
            arg_hi  <= 8'h00;
        end else if (state == ST_OP) begin
            arg_cnt <= 2'd0;
        end else if (state == ST_ARG && take) begin
            arg_cnt <= arg_cnt + 2'd1;
            if (arg_cnt == 2'd0) begin
                arg_lo <= mem_rdata_i;
            end else begin
                arg_hi <= mem_rdata_i;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            ptr_cnt  <= 2'd0;
            ptr_addr <= 16'h0000;
            ptr_hi   <= 8'h00;
            ptr_lo   <= 8'h00;
        end else if (state == ST_ARG && take && arg_cnt == 2'd0) begin
            ptr_cnt  <= 2'd0;
            ptr_addr <= {ZERO_PAGE, mem_rdata_i};
        end else if (state == ST_PTR && take) begin
            ptr_cnt  <= ptr_cnt + 2'd1;
            ptr_addr <= ptr_addr + 16'h0001;
            if (ptr_bytes(sel.mode) == 2'd2 && ptr_cnt == 2'd0) begin
                ptr_hi <= mem_rdata_i;
            end else begin
                ptr_lo <= mem_rdata_i;
            end
        end
    end

    // ------------------------------------------------------------------
    // effective address
    // ------------------------------------------------------------------
    // first arg byte is the high byte of a word
    logic [15:0] word_arg;
    logic [7:0]  idx;
    logic [7:0]  rel_off;
    logic [8:0]  short_sum;
    logic [15:0] next_addr;

    assign word_arg = {arg_lo, arg_hi};
    assign idx      = sel.use_y ? y_index_i : x_index_i;

    always_comb begin
        short_sum = 9'h000;
        next_addr = 16'h0000;
        rel_off   = 8'h00;
        case (sel.mode)
            MODE_DIR_S, MODE_BIT_D: next_addr = {ZERO_PAGE, arg_lo};
            MODE_BTR_D: begin
                next_addr = {ZERO_PAGE, arg_lo};
                rel_off   = arg_hi;
            end
            MODE_DIR_L: next_addr = word_arg;
            MODE_IDX_0: next_addr = {ZERO_PAGE, idx};
            MODE_IDX_S: begin
                short_sum = {1'b0, idx} + {1'b0, arg_lo};
                next_addr = {7'h00, short_sum};
            end
            MODE_IDX_L: next_addr = word_arg + {ZERO_PAGE, idx};
            MODE_IND_S, MODE_BIT_I: next_addr = {ZERO_PAGE, ptr_lo};
            MODE_BTR_I: begin
                next_addr = {ZERO_PAGE, ptr_lo};
                rel_off   = arg_hi;
            end
            MODE_IND_L: next_addr = {ptr_hi, ptr_lo};
            MODE_IIX_S: begin
                short_sum = {1'b0, idx} + {1'b0, ptr_lo};
                next_addr = {7'h00, short_sum};
            end
            MODE_IIX_L: next_addr = {ptr_hi, ptr_lo} + {ZERO_PAGE, idx};
            MODE_REL_D: rel_off = arg_lo;
            MODE_REL_I: rel_off = ptr_lo;
            default:    next_addr = 16'h0000;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            dec_o <= '0;
        end else if (state == ST_CALC) begin
            dec_o.opcode      <= opcode;
            dec_o.prebyte     <= pre;
            dec_o.mode        <= sel.mode;
            dec_o.use_y       <= sel.use_y;
            dec_o.combo_bad   <= sel.combo_bad;
            dec_o.length      <= {2'b00, pre != PRE_NONE} + 3'd1 + {1'b0, arg_bytes(sel.mode)};
            dec_o.operand     <= (sel.mode == MODE_IMM) ? arg_lo : 8'h00;
            dec_o.eff_addr    <= next_addr;
            dec_o.jump_target <= pc + {{8{rel_off[7]}}, rel_off};
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    sequence s_bad_fetch;
        state == ST_OP && take && bad_code;
    endsequence

    sequence s_trap_held;
        illegal_reset_o [*3];
    endsequence

    illegal_code_a: assert property (s_bad_fetch |=> s_trap_held)
        else $error("unknown code did not raise reset request");

    combo_no_reset_a: assert property (
        state == ST_OP && take && pre != PRE_NONE && is_prebyte(mem_rdata_i)
        |=> !illegal_reset_o [*2])
        else $error("prebyte combination raised reset request");

    imm_length_a: assert property (
        dec_valid_o && dec_o.mode == MODE_IMM
        |-> dec_o.length == ((dec_o.prebyte != PRE_NONE) ? 3'd3 : 3'd2)
            && dec_o.operand == arg_lo)
        else $error("immediate length or operand wrong");

    short_dir_a: assert property (
        dec_valid_o && dec_o.mode == MODE_DIR_S |-> dec_o.eff_addr == {8'h00, arg_lo})
        else $error("short direct address wrong");

    long_idx_a: assert property (
        $rose(dec_valid_o) && dec_o.mode == MODE_IDX_L
        |-> dec_o.eff_addr == {arg_lo, arg_hi} + {8'h00, $past(idx)})
        else $error("long indexed address wrong");

    short_idx_a: assert property (
        $rose(dec_valid_o) && dec_o.mode == MODE_IDX_S
        |-> dec_o.eff_addr == {7'h00, {1'b0, $past(idx)} + {1'b0, arg_lo}})
        else $error("short indexed sum lost its carry");

    ptr_follows_a: assert property (
        state == ST_ARG && take && arg_last && ptr_bytes(sel.mode) != 2'd0
        |=> state == ST_PTR && mem_addr_o == {8'h00, arg_lo})
        else $error("pointer read not issued at pointer address");

    rel_target_a: assert property (
        $rose(dec_valid_o) && dec_o.mode == MODE_REL_D
        |-> dec_o.jump_target == pc + {{8{arg_lo[7]}}, arg_lo})
        else $error("relative target not based on next pc");

    y_prebyte_a: assert property (
        state == ST_CALC && pre == PRE_Y && !sel.combo_bad && !pc_load_i
        |=> dec_valid_o && dec_o.use_y)
        else $error("Y prebyte did not select Y");

endmodule : cpuoad_decoder

// >>> hw/cpuoad_pkg.sv
/*
 * Shared constants and types of the operand addressing decoder: prebyte codes,
 * opcode map holes, addressing modes, decoder states and the decode result.
 * Assumes an 8-bit core with a 16-bit byte address space.
 */
package cpuoad_pkg;

    // ------------------------------------------------------------------
    // codes
    // ------------------------------------------------------------------
    localparam logic [7:0]  Y_REGISTER_PREBYTE       = 8'h90;
    localparam logic [7:0]  Y_INDIRECT_PREBYTE       = 8'h91;
    localparam logic [7:0]  INDIRECT_PREBYTE         = 8'h92;
    localparam logic [7:0]  RELATIVE_SUBROUTINE_CALL = 8'h8D;
    localparam logic [7:0]  ZERO_PAGE                = 8'h00;
    localparam logic [15:0] RESET_PC                 = 16'h0000;

    // legal low nibbles of the inherent opcode groups
    localparam logic [15:0] INH_LEGAL_GRP4 = 16'hF7DD;
    localparam logic [15:0] INH_LEGAL_GRP5 = 16'hF7DD;
    localparam logic [15:0] INH_LEGAL_GRP8 = 16'hFFE3;
    localparam logic [15:0] INH_LEGAL_GRP9 = 16'hFFFF;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PRE_NONE = 2'h0,
        PRE_Y    = 2'h1,
        PRE_IND  = 2'h2,
        PRE_YIND = 2'h3
    } cpuoad_pre_t;

    typedef enum logic [4:0] {
        MODE_INH   = 5'h00,
        MODE_IMM   = 5'h01,
        MODE_DIR_S = 5'h02,
        MODE_DIR_L = 5'h03,
        MODE_IDX_0 = 5'h04,
        MODE_IDX_S = 5'h05,
        MODE_IDX_L = 5'h06,
        MODE_IND_S = 5'h07,
        MODE_IND_L = 5'h08,
        MODE_IIX_S = 5'h09,
        MODE_IIX_L = 5'h0A,
        MODE_REL_D = 5'h0B,
        MODE_REL_I = 5'h0C,
        MODE_BIT_D = 5'h0D,
        MODE_BIT_I = 5'h0E,
        MODE_BTR_D = 5'h0F,
        MODE_BTR_I = 5'h10
    } cpuoad_mode_t;

    typedef enum logic [5:0] {
        ST_OP   = 6'h01,
        ST_ARG  = 6'h02,
        ST_PTR  = 6'h04,
        ST_CALC = 6'h08,
        ST_DONE = 6'h10,
        ST_TRAP = 6'h20
    } cpuoad_state_t;

    typedef struct packed {
        cpuoad_mode_t mode;
        logic         use_y;
        logic         combo_bad;
    } cpuoad_sel_t;

    typedef struct packed {
        logic [7:0]   opcode;
        cpuoad_pre_t  prebyte;
        cpuoad_mode_t mode;
        logic         use_y;
        logic         combo_bad;
        logic [2:0]   length;
        logic [7:0]   operand;
        logic [15:0]  eff_addr;
        logic [15:0]  jump_target;
    } cpuoad_dec_t;

endpackage : cpuoad_pkg

// >>> dv/cpuoad_mem_model.sv
/*
 * Program and data memory model answering the decoder's fetch port.
 * Assumes the bench fills the byte array and chooses the answer delay.
 */
`timescale 1ns/1ps

module cpuoad_mem_model (
    input  wire logic        core_clk_i,
    input  wire logic        reset_i,
    input  wire logic        en_i,
    input  wire logic [1:0]  wait_i,
    input  wire logic        mem_req_i,
    input  wire logic [15:0] mem_addr_i,
    output logic             mem_ack_o,
    output logic [7:0]       mem_rdata_o
);
    logic [7:0] mem [0:65535];
    logic [1:0] cnt;

    // ------------------------------------------------------------------
    // answer delay per request
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (reset_i || !mem_req_i || mem_ack_o) begin
            cnt <= 2'h0;
        end else if (cnt != 2'h3) begin
            cnt <= cnt + 2'h1;
        end
    end

    // ------------------------------------------------------------------
    // one-cycle ack; data toggles when not answering
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            mem_ack_o   <= 1'b0;
            mem_rdata_o <= 8'hA5;
        end else if (en_i && mem_req_i && !mem_ack_o && cnt >= wait_i) begin
            mem_ack_o   <= 1'b1;
            mem_rdata_o <= mem[mem_addr_i];
        end else begin
            mem_ack_o   <= 1'b0;
            mem_rdata_o <= ~mem_rdata_o;
        end
    end
endmodule : cpuoad_mem_model

// >>> dv/cpuoad_decoder_tb.sv
/*
 * Self-checking bench of the operand addressing decoder with a memory model.
 * Assumes the decoder restarts fetching at a loaded program counter.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[ERR] %0t mismatch got %0h exp %0h", $time, g, e); end end

module cpuoad_decoder_tb
    import cpuoad_pkg::*;
;
    logic core_clk_i, reset_i, pc_load_i, dec_ready_i, mem_en, mem_ack, dec_valid_o, illegal_o;
    logic [15:0] pc_value_i, mem_addr, pc;
    logic [7:0] x_index_i, y_index_i, mem_rdata, b1, b2, q1, q2, ptr;
    logic [1:0] wait_sel;
    logic mem_req;
    cpuoad_dec_t dec_o;
    logic [31:0] seed = 32'h4BEC;
    int n_mismatch = 0;
    int total_checks = 0;

    cpuoad_decoder DUT (.core_clk_i(core_clk_i), .reset_i(reset_i), .pc_load_i(pc_load_i),
        .pc_value_i(pc_value_i), .x_index_i(x_index_i), .y_index_i(y_index_i),
        .mem_req_o(mem_req), .mem_addr_o(mem_addr), .mem_ack_i(mem_ack),
        .mem_rdata_i(mem_rdata), .dec_valid_o(dec_valid_o), .dec_ready_i(dec_ready_i),
        .dec_o(dec_o), .illegal_reset_o(illegal_o));
    cpuoad_mem_model MEM (.core_clk_i(core_clk_i), .reset_i(reset_i), .en_i(mem_en),
        .wait_i(wait_sel), .mem_req_i(mem_req), .mem_addr_i(mem_addr),
        .mem_ack_o(mem_ack), .mem_rdata_o(mem_rdata));

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    function automatic logic [15:0] sx(input logic [7:0] v);
        return {{8{v[7]}}, v};
    endfunction : sx

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop

    // place bytes at pc, load pc, let memory answer until decode or trap
    task automatic run(input logic [7:0] pre, op, a1, a2, input int n);
        logic [15:0] p;
        int i;
        p = pc;
        if (pre != 8'h00) begin
            MEM.mem[p] = pre;
            p++;
        end
        MEM.mem[p] = op;
        MEM.mem[p + 16'h1] = a1;
        MEM.mem[p + 16'h2] = a2;
        @(posedge core_clk_i); #1;
        pc_load_i = 1'b1;
        pc_value_i = pc;
        @(posedge core_clk_i); #1;
        pc_load_i = 1'b0;
        wait_sel = xs() & 2'h3;
        mem_en = 1'b1;
        for (i = 0; i < 100 && dec_valid_o !== 1'b1 && illegal_o !== 1'b1; i++) begin
            @(posedge core_clk_i); #1;
        end
        mem_en = 1'b0;
        if (i == 100) begin
            n_mismatch++;
            $display("[ERR] %0t decode timeout", $time);
            report_and_stop();
        end
    endtask : run

    // compare length, register select and address (kind 1 operand, 2 jump)
    task automatic fin(input logic [2:0] len, input logic y, input logic [15:0] e, input int k);
        `CHK(dec_o.length, len)
        `CHK(dec_o.use_y, y)
        if (k == 0) `CHK(dec_o.eff_addr, e)
        if (k == 1) `CHK(dec_o.operand, e[7:0])
        if (k == 2) `CHK(dec_o.jump_target, e)
        `CHK(illegal_o, 1'b0)
        dec_ready_i = 1'b1;
        @(posedge core_clk_i); #1;
        dec_ready_i = 1'b0;
    endtask : fin

    initial begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end

    initial begin
        {pc_load_i, dec_ready_i, mem_en, wait_sel} = '0;
        {pc_value_i, x_index_i, y_index_i} = '0;
        reset_i = 1'b1;
        repeat (12) @(posedge core_clk_i);
        #1 reset_i = 1'b0;
        for (int t = 0; t < 12; t++) begin
            pc = {2'b01, 14'(xs())};
            {x_index_i, y_index_i, b1, b2} = xs();
            {q1, q2, ptr} = xs();
            if (t == 0) {x_index_i, y_index_i, b1, ptr} = 32'hFFFF_FF7F;
            MEM.mem[{8'h00, ptr}] = q1;
            MEM.mem[{8'h00, ptr} + 16'h1] = q2;
            run(8'h00, 8'hA6, b1, b2, 0); fin(2, 0, {8'h00, b1}, 1);
            run(8'h00, 8'hB6, b1, b2, 0); fin(2, 0, {8'h00, b1}, 0);
            run(8'h00, 8'hC6, b1, b2, 0); fin(3, 0, {b1, b2}, 0);
            run(8'h00, 8'hF6, b1, b2, 0); fin(1, 0, {8'h00, x_index_i}, 0);
            run(8'h00, 8'hE6, b1, b2, 0); fin(2, 0, x_index_i + b1 + 16'h0, 0);
            run(8'h00, 8'hD6, b1, b2, 0); fin(3, 0, {b1, b2} + x_index_i, 0);
            run(8'h90, 8'hE6, b1, b2, 0); fin(3, 1, y_index_i + b1 + 16'h0, 0);
            run(8'h90, 8'hF6, b1, b2, 0); fin(2, 1, {8'h00, y_index_i}, 0);
            run(8'h92, 8'hB6, ptr, b2, 0); fin(3, 0, {8'h00, q1}, 0);
            run(8'h92, 8'hC6, ptr, b2, 0); fin(3, 0, {q1, q2}, 0);
            run(8'h92, 8'hE6, ptr, b2, 0); fin(3, 0, q1 + x_index_i + 16'h0, 0);
            run(8'h92, 8'hD6, ptr, b2, 0); fin(3, 0, {q1, q2} + x_index_i, 0);
            run(8'h91, 8'hE6, ptr, b2, 0); fin(3, 1, q1 + y_index_i + 16'h0, 0);
            run(8'h00, 8'h20, b1, b2, 0); fin(2, 0, pc + 16'h2 + sx(b1), 2);
            run(8'h00, 8'h8D, b1, b2, 0); fin(2, 0, pc + 16'h2 + sx(b1), 2);
            run(8'h92, 8'h20, ptr, b2, 0); fin(3, 0, pc + 16'h3 + sx(q1), 2);
            run(8'h92, 8'h00, ptr, b2, 0); fin(4, 0, pc + 16'h4 + sx(b2), 2);
            run(8'h00, 8'h1C, b1, b2, 0); fin(2, 0, {8'h00, b1}, 0);
            run(8'h92, 8'h1C, ptr, b2, 0); fin(3, 0, {8'h00, q1}, 0);
            run(8'h00, 8'h0C, b1, b2, 0); fin(3, 0, pc + 16'h3 + sx(b2), 2);
            run(8'h00, 8'h9D, b1, b2, 0); fin(1, 0, 16'h0, 3);
            run(8'h00, 8'h3C, b1, b2, 0); fin(2, 0, {8'h00, b1}, 0);
            run(8'h00, 8'h7C, b1, b2, 0); fin(1, 0, {8'h00, x_index_i}, 0);
        end
        $display("test addressing modes done");
        run(8'h90, 8'h90, 8'hA6, b2, 0);
        `CHK(dec_o.combo_bad, 1'b1)
        `CHK(dec_o.opcode, 8'h90)
        `CHK(dec_o.mode, MODE_INH)
        fin(3'h2, 1'b0, '0, 3);
        run(8'h92, 8'hA6, b1, b2, 0);
        `CHK(dec_o.combo_bad, 1'b1)
        `CHK(dec_o.prebyte, PRE_IND)
        fin(3'h3, 1'b0, {8'h00, b1}, 1);
        $display("test prebyte combinations done");
        run(8'h00, 8'h41, b1, b2, 0);
        `CHK(illegal_o, 1'b1)
        repeat (3) @(posedge core_clk_i);
        #1 `CHK(illegal_o, 1'b1)
        reset_i = 1'b1;
        @(posedge core_clk_i); #1;
        reset_i = 1'b0;
        `CHK(illegal_o, 1'b0)
        $display("test illegal code done");
        report_and_stop();
    end
endmodule : cpuoad_decoder_tb
